// ==== logic/dsgc_top.sv ====
// Purpose: Deep-sleep clock gating control with run and sleep companions
// Assumes: AXI4-Lite slave, 32-bit data, power mode from a same-clock sequencer
// Notes:   Unit access faults at gated positions raise sticky interrupt status bits
//
// Design decision made here: the AXI4-Lite slave port.

`timescale 1ns/1ps
`default_nettype none

module dsgc_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address
  input  wire logic [dsgc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [dsgc_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Power mode from the sequencer
  input  wire dsgc_pkg::dsgc_mode_t          power_mode,
  // Unit access from the peripheral fabric
  input  wire logic                          unit_acc_valid,
  input  wire logic [4:0]                    unit_acc_bit,
  output logic                               unit_acc_done,
  output logic                               unit_acc_fault,
  // Clock enables to the gate cells, and the interrupt request
  output logic [dsgc_pkg::NUM_UNITS-1:0]     unit_clk_en,
  output logic                               irq
);

  dsgc_gate_if gif ();

  logic [31:0]                run_gate_reg;
  logic [31:0]                sleep_gate_reg;
  logic [31:0]                deep_gate_reg;
  logic [31:0]                config_reg;
  logic [31:0]                int_status_reg;
  logic [31:0]                int_mask_reg;
  logic [31:0]                eff_gate_next;
  logic                       auto_gating_select;

  // Write channel holding state
  logic                       aw_held_reg;
  logic [dsgc_pkg::ADDR_W-1:0] aw_addr_reg;
  logic                       w_held_reg;
  logic [31:0]                w_data_reg;
  logic [3:0]                 w_strb_reg;
  logic                       wr_fire;
  logic                       wr_hit;
  logic [31:0]                wr_bytes;
  logic [31:0]                ws_run;
  logic [31:0]                ws_sleep;
  logic [31:0]                ws_deep;
  logic [31:0]                ws_config;
  logic [31:0]                ws_status;
  logic [31:0]                ws_mask;

  // Read path
  logic                       rd_fire;
  logic                       rd_hit;
  logic [31:0]                rd_word;

  assign auto_gating_select = config_reg[dsgc_pkg::AUTO_GATING_SELECT_POS];

  // Word in force for the present mode
  always_comb
  begin
    eff_gate_next = run_gate_reg;
    if (auto_gating_select)
    begin
      unique case (power_mode)
        dsgc_pkg::DSGC_MODE_RUN:   eff_gate_next = run_gate_reg;
        dsgc_pkg::DSGC_MODE_SLEEP: eff_gate_next = sleep_gate_reg;
        dsgc_pkg::DSGC_MODE_DEEP:  eff_gate_next = deep_gate_reg;
        default:                   eff_gate_next = run_gate_reg;
      endcase
    end
  end

  assign gif.eff_gate  = eff_gate_next & dsgc_pkg::GATE_MASK;
  assign gif.acc_valid = unit_acc_valid;
  assign gif.acc_bit   = unit_acc_bit;

  dsgc_enable_bank u_enable_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .gif     (gif)
  );

  dsgc_access_guard u_access_guard (
    .aclk    (aclk),
    .aresetn (aresetn),
    .gif     (gif)
  );

  // All three come straight from flip-flops in the submodules
  assign unit_clk_en    = gif.clk_en;
  assign unit_acc_done  = gif.acc_done;
  assign unit_acc_fault = gif.acc_fault;

  // Write address and data are taken independently
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= '0;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (wr_fire)
      begin
        aw_held_reg   <= 1'b0;
      end
      else if (!aw_held_reg && !s_axi_bvalid)
      begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (wr_fire)
      begin
        w_held_reg   <= 1'b0;
      end
      else if (!w_held_reg && !s_axi_bvalid)
      begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wr_bytes[8*b +: 8] = {8{w_strb_reg[b]}};
  end

  always_comb
  begin
    ws_run    = 32'h0000_0000;
    ws_sleep  = 32'h0000_0000;
    ws_deep   = 32'h0000_0000;
    ws_config = 32'h0000_0000;
    ws_status = 32'h0000_0000;
    ws_mask   = 32'h0000_0000;
    wr_hit    = 1'b1;
    unique case (aw_addr_reg)
      dsgc_pkg::RUN_CLOCK_GATE_1_OFF:        ws_run    = wr_bytes;
      dsgc_pkg::SLEEP_CLOCK_GATE_1_OFF:      ws_sleep  = wr_bytes;
      dsgc_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFF: ws_deep   = wr_bytes;
      dsgc_pkg::RUN_CLOCK_CONFIG_OFF:        ws_config = wr_bytes;
      dsgc_pkg::INT_STATUS_OFF:              ws_status = wr_bytes;
      dsgc_pkg::INT_MASK_OFF:                ws_mask   = wr_bytes;
      default:                               wr_hit    = 1'b0;
    endcase
    if (!wr_fire)
    begin
      ws_run    = 32'h0000_0000;
      ws_sleep  = 32'h0000_0000;
      ws_deep   = 32'h0000_0000;
      ws_config = 32'h0000_0000;
      ws_status = 32'h0000_0000;
      ws_mask   = 32'h0000_0000;
    end
  end

  // Only writable bits ever change
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      run_gate_reg <= dsgc_pkg::GATE_RESET;
    else
      run_gate_reg <= (run_gate_reg & ~(ws_run & dsgc_pkg::GATE_MASK))
                    | (w_data_reg & ws_run & dsgc_pkg::GATE_MASK);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sleep_gate_reg <= dsgc_pkg::GATE_RESET;
    else
      sleep_gate_reg <= (sleep_gate_reg & ~(ws_sleep & dsgc_pkg::GATE_MASK))
                      | (w_data_reg & ws_sleep & dsgc_pkg::GATE_MASK);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      deep_gate_reg <= dsgc_pkg::GATE_RESET;
    else
      deep_gate_reg <= (deep_gate_reg & ~(ws_deep & dsgc_pkg::GATE_MASK))
                     | (w_data_reg & ws_deep & dsgc_pkg::GATE_MASK);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      config_reg <= dsgc_pkg::CONFIG_RESET;
    else
      config_reg <= (config_reg & ~(ws_config & dsgc_pkg::CONFIG_MASK))
                  | (w_data_reg & ws_config & dsgc_pkg::CONFIG_MASK);
  end

  // Fault events set, write one clears, a new fault beats the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_status_reg <= dsgc_pkg::INT_RESET;
    else
      int_status_reg <= ((int_status_reg & ~(ws_status & w_data_reg))
                       | gif.fault_word) & dsgc_pkg::GATE_MASK;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_mask_reg <= dsgc_pkg::INT_RESET;
    else
      int_mask_reg <= (int_mask_reg & ~(ws_mask & dsgc_pkg::GATE_MASK))
                    | (w_data_reg & ws_mask & dsgc_pkg::GATE_MASK);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(int_status_reg & int_mask_reg);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dsgc_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? dsgc_pkg::RESP_OKAY : dsgc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side: one read under way at a time
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      dsgc_pkg::RUN_CLOCK_GATE_1_OFF:        rd_word = run_gate_reg;
      dsgc_pkg::SLEEP_CLOCK_GATE_1_OFF:      rd_word = sleep_gate_reg;
      dsgc_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFF: rd_word = deep_gate_reg;
      dsgc_pkg::RUN_CLOCK_CONFIG_OFF:        rd_word = config_reg;
      dsgc_pkg::INT_STATUS_OFF:              rd_word = int_status_reg;
      dsgc_pkg::INT_MASK_OFF:                rd_word = int_mask_reg;
      default:                               rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_arready <= 1'b0;
    else if (rd_fire)
      s_axi_arready <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dsgc_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? dsgc_pkg::RESP_OKAY : dsgc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : dsgc_top

`default_nettype wire

// ==== logic/dsgc_pkg.sv ====
// Purpose: Constants and types shared by the deep-sleep clock gating block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Gating registers share one bit layout

`default_nettype none

package dsgc_pkg;

  // Register byte offsets
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFF        = 12'h060;
  localparam logic [11:0] RUN_CLOCK_GATE_1_OFF        = 12'h104;
  localparam logic [11:0] SLEEP_CLOCK_GATE_1_OFF      = 12'h114;
  localparam logic [11:0] DEEP_SLEEP_CLOCK_GATE_1_OFF = 12'h124;
  localparam logic [11:0] INT_STATUS_OFF              = 12'h200;
  localparam logic [11:0] INT_MASK_OFF                = 12'h204;

  localparam int ADDR_W = 12;
  localparam int NUM_UNITS = 11;

  // Bit positions of the gated units, ordered as the clock enable outputs
  localparam int UART0_POS    = 0;
  localparam int UART1_POS    = 1;
  localparam int SSI_POS      = 4;
  localparam int QEI_POS      = 8;
  localparam int TWI_POS      = 12;
  localparam int TIMER0_POS   = 16;
  localparam int TIMER1_POS   = 17;
  localparam int TIMER2_POS   = 18;
  localparam int COMPARATOR_ZERO_GATE_POS    = 24;
  localparam int COMPARATOR_ONE_GATE_POS    = 25;
  localparam int COMPARATOR_TWO_GATE_POS    = 26;
  localparam int UNIT_POS [NUM_UNITS] = '{
    UART0_POS, UART1_POS, SSI_POS, QEI_POS, TWI_POS, TIMER0_POS,
    TIMER1_POS, TIMER2_POS, COMPARATOR_ZERO_GATE_POS, COMPARATOR_ONE_GATE_POS, COMPARATOR_TWO_GATE_POS
  };

  // Writable bits of every gating word; all others read zero
  localparam logic [31:0] GATE_MASK  = 32'h0707_1113;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;

  localparam int AUTO_GATING_SELECT_POS = 22;
  localparam logic [31:0] CONFIG_MASK  = 32'h0040_0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] INT_RESET    = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DSGC_MODE_RUN,
    DSGC_MODE_SLEEP,
    DSGC_MODE_DEEP
  } dsgc_mode_t;

endpackage : dsgc_pkg

`default_nettype wire

// ==== logic/dsgc_gate_if.sv ====
// Purpose: Carries gating words and unit access events between the modules
// Assumes: Single clock domain
// Notes:   Top drives selection and access inputs; leaves answer

`timescale 1ns/1ps
`default_nettype none

interface dsgc_gate_if;
  logic [31:0]                  eff_gate;
  logic [31:0]                  live_word;
  logic [dsgc_pkg::NUM_UNITS-1:0] clk_en;
  logic                         acc_valid;
  logic [4:0]                   acc_bit;
  logic                         acc_fault;
  logic                         acc_done;
  logic [31:0]                  fault_word;

  modport top  (output eff_gate, output acc_valid, output acc_bit,
                input live_word, input clk_en, input acc_fault, input acc_done,
                input fault_word);
  modport gate (input eff_gate, output live_word, output clk_en);
  modport fault (input live_word, input acc_valid, input acc_bit,
                 output acc_fault, output acc_done, output fault_word);
endinterface : dsgc_gate_if

`default_nettype wire

// ==== logic/dsgc_enable_bank.sv ====
// Purpose: Registered clock enables, one per gated unit
// Assumes: Enables feed latch-based clock gate cells outside this block
// Notes:   Enables change only just after a rising edge

`timescale 1ns/1ps
`default_nettype none

module dsgc_enable_bank (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  dsgc_gate_if.gate  gif
);

  // Unattached bit positions never reach an enable and read as off
  genvar i;
  generate
    for (i = 0; i < dsgc_pkg::NUM_UNITS; i++)
    begin : g_unit
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          gif.clk_en[i] <= 1'b0;
        else
          gif.clk_en[i] <= gif.eff_gate[dsgc_pkg::UNIT_POS[i]];
      end
    end
  endgenerate

  always_comb
  begin
    gif.live_word = 32'h0000_0000;
    for (int k = 0; k < dsgc_pkg::NUM_UNITS; k++)
      gif.live_word[dsgc_pkg::UNIT_POS[k]] = gif.clk_en[k];
  end

endmodule : dsgc_enable_bank

`default_nettype wire

// ==== logic/dsgc_access_guard.sv ====
// Purpose: Answers each unit access as completed or bus fault
// Assumes: One access strobe per cycle from the fabric on the same clock
// Notes:   Answer is one cycle after the strobe

`timescale 1ns/1ps
`default_nettype none

module dsgc_access_guard (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  dsgc_gate_if.fault gif
);

  logic gated_off;

  assign gated_off = ~gif.live_word[gif.acc_bit];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gif.acc_done   <= 1'b0;
      gif.acc_fault  <= 1'b0;
      gif.fault_word <= 32'h0000_0000;
    end
    else
    begin
      gif.acc_done   <= gif.acc_valid;
      gif.acc_fault  <= gif.acc_valid & gated_off;
      gif.fault_word <= (gif.acc_valid & gated_off) ? (32'h0000_0001 << gif.acc_bit)
                                                    : 32'h0000_0000;
    end
  end

endmodule : dsgc_access_guard

`default_nettype wire

// ==== sim/dsgc_top_assertions.sv ====
// Purpose: Port checks for the gating block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to dsgc_top from the bench top file
`timescale 1ns/1ps
`default_nettype none
module dsgc_top_assertions (
  input wire logic                           aclk,
  input wire logic                           aresetn,
  input wire logic                           s_axi_awvalid,
  input wire logic                           s_axi_awready,
  input wire logic [1:0]                     s_axi_bresp,
  input wire logic                           s_axi_bvalid,
  input wire logic                           s_axi_bready,
  input wire logic                           s_axi_arvalid,
  input wire logic                           s_axi_arready,
  input wire logic [31:0]                    s_axi_rdata,
  input wire logic [1:0]                     s_axi_rresp,
  input wire logic                           s_axi_rvalid,
  input wire logic                           s_axi_rready,
  input wire dsgc_pkg::dsgc_mode_t           power_mode,
  input wire logic                           unit_acc_valid,
  input wire logic [4:0]                     unit_acc_bit,
  input wire logic                           unit_acc_done,
  input wire logic                           unit_acc_fault,
  input wire logic [dsgc_pkg::NUM_UNITS-1:0] unit_clk_en,
  input wire logic                           irq
);
  logic exp_fault_reg;

  function automatic logic unit_on(input logic [4:0] b,
                                   input logic [dsgc_pkg::NUM_UNITS-1:0] en);
    unit_on = 1'b0;
    for (int i = 0; i < dsgc_pkg::NUM_UNITS; i++)
      if (dsgc_pkg::UNIT_POS[i] == b) unit_on = en[i];
  endfunction : unit_on

  // Fault expected one cycle after an access to an unclocked position
  always_ff @(posedge aclk)
    exp_fault_reg <= unit_acc_valid && !unit_on(unit_acc_bit, unit_clk_en);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_done_follows: assert property (unit_acc_valid |=> unit_acc_done)
    else $error("access not answered");
  a_done_only_after: assert property (!unit_acc_valid |=> !unit_acc_done)
    else $error("answer without access");
  a_fault_matches_gate: assert property (unit_acc_done |-> unit_acc_fault == exp_fault_reg)
    else $error("fault does not match gate state");
  a_reset_clears: assert property ($rose(aresetn) |-> unit_clk_en == '0 && !irq)
    else $error("enables not cleared by reset");
  a_enable_cause: assert property ($changed(unit_clk_en) |->
    ($past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)) || $past(power_mode) != $past(power_mode, 2))
    else $error("enables changed without cause");
  a_reserved_zero: assert property (s_axi_rvalid |->
    (s_axi_rdata & ~(dsgc_pkg::GATE_MASK | dsgc_pkg::CONFIG_MASK)) == '0)
    else $error("reserved bits read nonzero");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_awready_drops: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready stayed high");
endmodule : dsgc_top_assertions
`default_nettype wire

// ==== sim/dsgc_unit_model.sv ====
// Purpose: Gated peripheral units that run only on passed clock cycles
// Assumes: Enables feed ideal gate cells
// Notes:   Each unit counts the clock cycles it receives
`timescale 1ns/1ps
`default_nettype none
module dsgc_unit_model (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [dsgc_pkg::NUM_UNITS-1:0] clk_en,
  output logic [15:0]                         ticks [dsgc_pkg::NUM_UNITS]
);
  always_ff @(posedge aclk)
    for (int i = 0; i < dsgc_pkg::NUM_UNITS; i++)
      if (!aresetn) ticks[i] <= 16'h0;
      else if (clk_en[i]) ticks[i] <= ticks[i] + 16'h1;
endmodule : dsgc_unit_model
`default_nettype wire

// ==== sim/dsgc_bench.sv ====
// Purpose: Self-checking bench for the gating block
// Assumes: Registers over AXI4-Lite, unit accesses driven by the bench
// Notes:   Ready inputs are held high throughout
`timescale 1ns/1ps
`default_nettype none
module dsgc_bench;
  localparam logic [31:0] RUN_W  = 32'h0000_0003;
  localparam logic [31:0] SLP_W  = 32'h0003_0010;
  localparam logic [31:0] DEEP_W = 32'h0700_0100;
  localparam logic [11:0] REGS [6] = '{dsgc_pkg::RUN_CLOCK_CONFIG_OFF,
    dsgc_pkg::RUN_CLOCK_GATE_1_OFF, dsgc_pkg::SLEEP_CLOCK_GATE_1_OFF,
    dsgc_pkg::DEEP_SLEEP_CLOCK_GATE_1_OFF, dsgc_pkg::INT_STATUS_OFF, dsgc_pkg::INT_MASK_OFF};
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, unit_acc_valid, unit_acc_done, unit_acc_fault, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [4:0]  unit_acc_bit;
  logic [10:0] unit_clk_en;
  logic [15:0] ticks [dsgc_pkg::NUM_UNITS];
  logic [15:0] t_on, t_off;
  dsgc_pkg::dsgc_mode_t power_mode;
  int num_errors = 0;
  int checked = 0;

  dsgc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .power_mode, .unit_acc_valid, .unit_acc_bit, .unit_acc_done,
    .unit_acc_fault, .unit_clk_en, .irq);
  dsgc_unit_model i_units (.aclk, .aresetn, .clk_en(unit_clk_en), .ticks);

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    check(s_axi_rdata, exp, "read data");
    check(32'(s_axi_rresp), 32'(er), "read response");
  endtask : rchk

  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask : settle

  function automatic logic [10:0] en_of(input logic [31:0] w);
    for (int i = 0; i < dsgc_pkg::NUM_UNITS; i++)
      en_of[i] = w[dsgc_pkg::UNIT_POS[i]];
  endfunction : en_of

  task automatic en_chk(input logic [31:0] w);
    settle();
    check(32'(unit_clk_en), 32'(en_of(w)), "clock enables");
    @(posedge aclk);
  endtask : en_chk

  task automatic access(input logic [4:0] b, input logic exp_fault);
    unit_acc_valid <= 1'b1;
    unit_acc_bit <= b;
    @(posedge aclk);
    unit_acc_valid <= 1'b0;
    #1;
    check(32'(unit_acc_done), 32'h1, "access done");
    check(32'(unit_acc_fault), 32'(exp_fault), "access fault");
    @(posedge aclk);
  endtask : access

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #(100 * 5000);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, unit_acc_valid} = 4'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, unit_acc_bit} = '0;
    power_mode = dsgc_pkg::DSGC_MODE_RUN;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (REGS[i]) rchk(REGS[i], 32'h0, dsgc_pkg::RESP_OKAY);
    check(32'(unit_clk_en), 32'h0, "enables after reset");
    $display("test reset values done");
    for (int i = 1; i < 4; i++)
    begin
      wr(REGS[i], 32'hffff_ffff);
      rchk(REGS[i], dsgc_pkg::GATE_MASK, dsgc_pkg::RESP_OKAY);
      wr(REGS[i], ~dsgc_pkg::GATE_MASK);
      rchk(REGS[i], 32'h0, dsgc_pkg::RESP_OKAY);
    end
    wr(REGS[0], 32'hffff_ffff);
    rchk(REGS[0], dsgc_pkg::CONFIG_MASK, dsgc_pkg::RESP_OKAY);
    wr(REGS[0], 32'h0);
    wr(12'h128, 32'hffff_ffff);
    check(32'(resp), 32'(dsgc_pkg::RESP_SLVERR), "unmapped write");
    rchk(12'h128, 32'h0, dsgc_pkg::RESP_SLVERR);
    wr(REGS[1], RUN_W);
    check(32'(resp), 32'(dsgc_pkg::RESP_OKAY), "mapped write");
    wr(REGS[2], SLP_W);
    wr(REGS[3], DEEP_W);
    rchk(REGS[3], DEEP_W, dsgc_pkg::RESP_OKAY);
    rchk(REGS[1], RUN_W, dsgc_pkg::RESP_OKAY);
    $display("test register fields done");
    en_chk(RUN_W);
    power_mode <= dsgc_pkg::DSGC_MODE_DEEP;
    en_chk(RUN_W);
    wr(REGS[0], dsgc_pkg::CONFIG_MASK);
    en_chk(DEEP_W);
    power_mode <= dsgc_pkg::DSGC_MODE_SLEEP;
    en_chk(SLP_W);
    power_mode <= dsgc_pkg::DSGC_MODE_RUN;
    en_chk(RUN_W);
    power_mode <= dsgc_pkg::DSGC_MODE_DEEP;
    en_chk(DEEP_W);
    t_on = ticks[8];
    t_off = ticks[0];
    repeat (10) @(posedge aclk);
    check(32'(ticks[8] - t_on), 32'h0000_000a, "clocked unit cycles");
    check(32'(ticks[0]), 32'(t_off), "stopped unit cycles");
    $display("test mode selection done");
    for (int i = 0; i < dsgc_pkg::NUM_UNITS; i++)
      access(5'(dsgc_pkg::UNIT_POS[i]), !DEEP_W[dsgc_pkg::UNIT_POS[i]]);
    access(5'h02, 1'b1);
    access(5'h1f, 1'b1);
    rchk(REGS[4], dsgc_pkg::GATE_MASK & ~DEEP_W, dsgc_pkg::RESP_OKAY);
    check(32'(irq), 32'h0, "irq while masked");
    wr(REGS[5], 32'h0000_0010);
    settle();
    check(32'(irq), 32'h1, "irq raised");
    @(posedge aclk);
    wr(REGS[4], 32'h0000_0010);
    settle();
    check(32'(irq), 32'h0, "irq cleared");
    @(posedge aclk);
    rchk(REGS[4], dsgc_pkg::GATE_MASK & ~DEEP_W & 32'hffff_ffef, dsgc_pkg::RESP_OKAY);
    $display("test access faults done");
    finish_test();
  end
endmodule : dsgc_bench

bind dsgc_top dsgc_top_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode, .unit_acc_valid, .unit_acc_bit,
  .unit_acc_done, .unit_acc_fault, .unit_clk_en, .irq);
`default_nettype wire
